// ==== design/ahp_fifo.sv ====
`timescale 1ns/1ps
module ahp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("ahp_fifo: DEPTH must be a power of two >= 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready_out = !((wr_ptr[AW] != rd_ptr[AW]) &&
                          (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid_out = (wr_ptr != rd_ptr);
  assign out_data_out = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // ahp_fifo

// ==== design/ahp_host_port.sv ====
// Overview of operation
// - Pin-selected mode converts the pair coded on pair_select, 000 to 111.
// - Pair select is sampled on leaving full or partial reset.
// - After reset, pair select is sampled while busy is high.
// - Register-selected mode uses the channel register, reset to pair 0.
// - Rising conversion start begins conversion; busy high until results ready.
// - Parallel bus driven only while chip select and read are both low.
// - Chip select rising releases the bus; falling allows driving again.
// - First read after busy falls gives A result, next gives B.
// - Writing zero to address zero leaves register readback mode; in pin-selected mode the write is ignored and readback mode holds.
// - Write word: bit 15 set, address bits 14..9, data bits 8..0.
// - Register write is one 16-bit access captured on write rising edge.
// - Register writes accepted only in register-selected mode.
// - Read command: bit 15 clear, address bits 14..9, low bits ignored.
// - Read command copies the addressed register to the output register.
// - Returned register words carry the address in bits 14..9.
// - Bus bit 0 is the least significant bit of every word.
// - Dual-line: A on first output, B on second; single-line sends A then B on the first.
// - Single or dual line choice is latched only leaving full reset.
// - Serial chip select falling enables outputs with MSB; rising clock shifts.
// - Single-line sends A before B in 32 serial clocks.
`timescale 1ns/1ps
module ahp_host_port
  import ahp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic partial_reset_in,
  input wire logic pin_mode_in,
  input wire logic interface_select_in,
  input wire logic single_line_select_in,
  input wire logic [2:0] pair_select_in,
  input wire logic conversion_start_in,
  output logic busy_out,
  output logic conversion_request_out,
  output logic [2:0] conversion_pair_out,
  input wire logic result_valid_in,
  input wire ahp_result_t result_in,
  output logic result_ready_out,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic serial_clock_in,
  input wire logic [15:0] parallel_data_bus_in,
  output logic [15:0] parallel_data_bus_out,
  output logic parallel_data_bus_oe_out,
  output logic serial_out_first_out,
  output logic serial_out_first_oe_out,
  output logic serial_out_second_out,
  output logic serial_out_second_oe_out
);
  initial begin
    if (DEPTH < 2) begin
      $error("ahp_host_port: DEPTH too small");
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and reset exit
  // ----------------------------------------------------------------
  logic cs_prev, rd_prev, wr_prev, conv_prev, sclk_prev;
  logic in_full_rst, in_part_rst;
  logic cs_fall, cs_rise, rd_fall, wr_rise, conv_rise, sclk_rise;
  logic full_exit, any_exit, soft_rst;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cs_prev <= 1'b1;
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
      conv_prev <= 1'b1;
      sclk_prev <= 1'b1;
    end else begin
      cs_prev <= cs_n_in;
      rd_prev <= rd_n_in;
      wr_prev <= wr_n_in;
      conv_prev <= conversion_start_in;
      sclk_prev <= serial_clock_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      in_full_rst <= 1'b1;
      in_part_rst <= 1'b0;
    end else begin
      in_full_rst <= 1'b0;
      in_part_rst <= partial_reset_in;
    end
  end

  assign cs_fall = cs_prev && !cs_n_in;
  assign cs_rise = !cs_prev && cs_n_in;
  assign rd_fall = rd_prev && !rd_n_in && !cs_n_in;
  assign wr_rise = !wr_prev && wr_n_in && !cs_n_in;
  assign conv_rise = !conv_prev && conversion_start_in;
  assign sclk_rise = !sclk_prev && serial_clock_in && !cs_n_in;
  assign full_exit = in_full_rst;
  assign any_exit = in_full_rst || (in_part_rst && !partial_reset_in);
  assign soft_rst = partial_reset_in;

  // ----------------------------------------------------------------
  // Latched configuration
  // ----------------------------------------------------------------
  logic pin_mode, single_line;

  // latch line count
  // Straps are caught on the first clock after full reset release
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pin_mode <= 1'b0;
      single_line <= 1'b0;
    end else if (full_exit) begin
      pin_mode <= pin_mode_in;
      single_line <= !single_line_select_in;
    end
  end

  // ----------------------------------------------------------------
  // Channel pair selection
  // ----------------------------------------------------------------
  logic [2:0] hw_pair, channel_reg, next_pair;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      hw_pair <= CHANNEL_RESET;
    end else if (any_exit || busy_out) begin
      hw_pair <= pair_select_in;
    end
  end

  assign next_pair = pin_mode ? hw_pair : channel_reg;

  // ----------------------------------------------------------------
  // Conversion control
  // ----------------------------------------------------------------
  ahp_conv_state_t state;
  logic fifo_in_ready, fifo_out_valid, push, start_ok;
  ahp_result_t head;
  logic pop;

  assign start_ok = conv_rise && (state == ST_IDLE) && fifo_in_ready;
  assign result_ready_out = fifo_in_ready && (state == ST_BUSY);
  assign push = result_valid_in && result_ready_out;
  assign busy_out = (state == ST_BUSY);

  // start and busy
  // Starts while full are dropped so no result can be lost
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || soft_rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_ok) begin
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (push) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      conversion_request_out <= 1'b0;
      conversion_pair_out <= CHANNEL_RESET;
    end else begin
      conversion_request_out <= start_ok && !soft_rst;
      if (start_ok) begin
        conversion_pair_out <= next_pair;
      end
    end
  end

  ahp_fifo #(
    .WIDTH($bits(ahp_result_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .flush_in(soft_rst),
    .in_valid_in(result_valid_in && busy_out),
    .in_data_in(result_in),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(head),
    .out_ready_in(pop)
  );

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  ahp_cmd_t cmd;
  logic reg_mode, reg_we;
  logic [5:0] rb_addr;
  logic [8:0] mem_rdata;
  logic [15:0] reg_word;

  assign cmd = ahp_cmd_t'(parallel_data_bus_in);
  assign reg_we = wr_rise && !interface_select_in && cmd.write &&
                  !pin_mode;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      channel_reg <= CHANNEL_RESET;
    end else if (reg_we && cmd.addr == CHANNEL_REG_ADDR) begin
      channel_reg <= cmd.data[2:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      reg_mode <= 1'b0;
      rb_addr <= EXIT_ADDR;
    end else if (wr_rise && !interface_select_in) begin
      if (!cmd.write) begin
        reg_mode <= 1'b1;
        rb_addr <= cmd.addr;
      end else if (reg_we && cmd.addr == EXIT_ADDR &&
                   cmd.data == EXIT_DATA) begin
        reg_mode <= 1'b0;
      end
    end
  end

  ahp_regmem u_regmem (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(reg_we),
    .wr_addr_in(cmd.addr),
    .wr_data_in(cmd.data),
    .rd_addr_in(rb_addr),
    .rd_data_out(mem_rdata)
  );

  assign reg_word = {1'b0, rb_addr,
                     (rb_addr == CHANNEL_REG_ADDR) ?
                     {6'h00, channel_reg} : mem_rdata};

  // ----------------------------------------------------------------
  // Parallel readout
  // ----------------------------------------------------------------
  logic ab_ptr, par_pop, ser_pop;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || soft_rst) begin
      ab_ptr <= 1'b0;
    end else if (push) begin
      ab_ptr <= 1'b0;
    end else if (rd_fall && !interface_select_in && !reg_mode) begin
      ab_ptr <= !ab_ptr;
    end
  end

  assign par_pop = rd_fall && !interface_select_in && !reg_mode &&
                   ab_ptr && !push && fifo_out_valid;
  assign pop = par_pop || ser_pop;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      parallel_data_bus_out <= 16'h0000;
    end else if (rd_fall && !interface_select_in) begin
      parallel_data_bus_out <= reg_mode ? reg_word :
                               (ab_ptr ? head.b : head.a);
    end
  end

  assign parallel_data_bus_oe_out = !cs_n_in && !rd_n_in &&
                                    !interface_select_in;

  // ----------------------------------------------------------------
  // Serial readout
  // ----------------------------------------------------------------
  logic [31:0] sh_first;
  logic [15:0] sh_second;
  logic [5:0] bit_cnt, bit_limit;

  assign bit_limit = single_line ? SERIAL_BITS_SINGLE : SERIAL_BITS_DUAL;
  assign ser_pop = sclk_rise && interface_select_in && !reg_mode &&
                   (bit_cnt + 6'h01 == bit_limit);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || soft_rst) begin
      sh_first <= 32'h00000000;
      sh_second <= 16'h0000;
      bit_cnt <= 6'h00;
    end else if (interface_select_in && cs_fall) begin
      bit_cnt <= 6'h00;
      sh_second <= reg_mode ? reg_word : head.b;
      if (reg_mode) begin
        sh_first <= {reg_word, 16'h0000};
      end else if (single_line) begin
        sh_first <= {head.a, head.b};
      end else begin
        sh_first <= {head.a, 16'h0000};
      end
    end else if (interface_select_in && sclk_rise &&
                 bit_cnt != bit_limit) begin
      sh_first <= {sh_first[30:0], 1'b0};
      sh_second <= {sh_second[14:0], 1'b0};
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  assign serial_out_first_out = sh_first[31];
  assign serial_out_second_out = sh_second[15];
  // second line only in dual mode
  assign serial_out_first_oe_out = !cs_n_in && interface_select_in;
  assign serial_out_second_oe_out = !cs_n_in && interface_select_in &&
                                    !single_line;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // drive gate
  a_bus_drive_gate: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) parallel_data_bus_oe_out |->
      (!cs_n_in && !rd_n_in && !interface_select_in))
    else $error("bus driven outside read window");

  a_cs_release: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) cs_rise |-> !parallel_data_bus_oe_out)
    else $error("bus not released after cs rise");

  a_first_read_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in || soft_rst)
    (rd_fall && !interface_select_in && !reg_mode && !ab_ptr && !push)
      |=> parallel_data_bus_out == $past(head.a))
    else $error("first read did not return A result");

  a_busy_start: assert property (@(posedge clock_in)
    disable iff (!rst_n_in || soft_rst)
    start_ok |=> busy_out && conversion_request_out &&
      conversion_pair_out == $past(next_pair))
    else $error("start did not raise busy");

  a_exit_regmode: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    (reg_we && cmd.addr == EXIT_ADDR && cmd.data == EXIT_DATA)
      |=> !reg_mode)
    else $error("zero write did not leave readback mode");

  a_hw_write_block: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) (pin_mode && !full_exit) |=>
      $stable(channel_reg))
    else $error("channel register changed in pin mode");

  a_regread_addr: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    (wr_rise && !interface_select_in && !cmd.write) |=>
      reg_mode && reg_word[14:9] == $past(cmd.addr))
    else $error("readback word lacks address");

  a_pointer_reset: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) $fell(busy_out) |-> !ab_ptr)
    else $error("A/B pointer not reset when busy fell");

  a_serial_msb: assert property (@(posedge clock_in)
    disable iff (!rst_n_in || soft_rst)
    (interface_select_in && cs_fall && !reg_mode) |=>
      serial_out_first_out == $past(head.a[15]))
    else $error("serial MSB not presented");
endmodule // ahp_host_port

// ==== design/ahp_pkg.sv ====
package ahp_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int CMD_WRITE_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 9;
  localparam int DATA_MSB = 8;
  localparam int ADDR_W = 6;
  localparam int REG_DATA_W = 9;
  localparam int PAIR_W = 3;

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] EXIT_ADDR = 6'h00;
  localparam logic [8:0] EXIT_DATA = 9'h000;
  localparam logic [5:0] CHANNEL_REG_ADDR = 6'h03;
  localparam logic [2:0] CHANNEL_RESET = 3'h0;
  localparam logic [8:0] REG_RESET = 9'h000;

  // ----------------------------------------------------------------
  // Buffering and serial counts
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 32;
  localparam logic [5:0] SERIAL_BITS_DUAL = 6'h10;
  localparam logic [5:0] SERIAL_BITS_SINGLE = 6'h20;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
  } ahp_result_t;

  typedef struct packed {
    logic write;
    logic [5:0] addr;
    logic [8:0] data;
  } ahp_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } ahp_conv_state_t;

endpackage

// ==== design/ahp_regmem.sv ====
`timescale 1ns/1ps
module ahp_regmem
  import ahp_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = REG_DATA_W
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);
  initial begin
    if (AW < 1 || DW < 1) begin
      $error("ahp_regmem: widths must be positive");
    end
  end

  logic [DW-1:0] mem [2**AW];

  // Reset clears every word, so readback never shows unknowns
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem[i] <= DW'(REG_RESET);
      end
    end else if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule // ahp_regmem

// ==== test/adc_host_readout_port_tb.sv ====
`timescale 1ns/1ps
module adc_host_readout_port_tb
  import ahp_pkg::*;
;
  logic clock_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic partial_reset_in = 1'h0;
  logic pin_mode_in = 1'h1;
  logic interface_select_in = 1'h0;
  logic single_line_select_in = 1'h1;
  logic [2:0] pair_select_in = 3'h0;
  logic conversion_start_in = 1'h0;
  logic cs_n_in = 1'h1;
  logic rd_n_in = 1'h1;
  logic wr_n_in = 1'h1;
  logic serial_clock_in = 1'h0;
  logic [15:0] parallel_data_bus_in = 16'h0000;
  logic [7:0] delay = 8'h03;
  logic busy_out, conversion_request_out, result_valid_in, result_ready_out;
  logic parallel_data_bus_oe_out, serial_out_first_out;
  logic serial_out_first_oe_out, serial_out_second_out;
  logic serial_out_second_oe_out;
  logic [2:0] conversion_pair_out;
  logic [15:0] parallel_data_bus_out, va;
  ahp_result_t result_in;
  logic [31:0] f1, f2;
  logic [2:0] pp = 3'h2;
  int num_errors = 0;
  int n_checks = 0;
  int seq = 0;
  int base = 0;
  int cycles = 0;

  always #25 clock_in = ~clock_in;

  ahp_host_port #(.DEPTH(FIFO_DEPTH)) DUT (.clock_in, .rst_n_in,
    .partial_reset_in, .pin_mode_in, .interface_select_in,
    .single_line_select_in, .pair_select_in, .conversion_start_in,
    .busy_out, .conversion_request_out, .conversion_pair_out,
    .result_valid_in, .result_in, .result_ready_out, .cs_n_in, .rd_n_in,
    .wr_n_in, .serial_clock_in, .parallel_data_bus_in,
    .parallel_data_bus_out, .parallel_data_bus_oe_out,
    .serial_out_first_out, .serial_out_first_oe_out,
    .serial_out_second_out, .serial_out_second_oe_out);

  ahp_core_model core (.clock_in, .rst_n_in,
    .request_in(conversion_request_out), .pair_in(conversion_pair_out),
    .ready_in(result_ready_out), .delay_in(delay),
    .valid_out(result_valid_in), .result_out(result_in));

  // ----------------------------------------------
  // Checking and closing
  // ----------------------------------------------
  task automatic stop_test();
    $display("TB: checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ceiling far above the roughly 1700 cycles the tests need
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      $display("BAD %0t run did not finish", $time);
      stop_test();
    end
  end

  function automatic logic [15:0] av(input logic [2:0] p, input int s);
    return {1'h0, p, s[11:0]};
  endfunction

  function automatic logic [15:0] bv(input logic [2:0] p, input int s);
    return ~av(p, s);
  endfunction

  // ----------------------------------------------
  // Host access tasks
  // ----------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  task automatic full_reset(input logic pin, input logic dual,
                            input logic [2:0] p);
    rst_n_in <= 1'h0;
    pin_mode_in <= pin;
    single_line_select_in <= dual;
    pair_select_in <= p;
    tick(2);
    rst_n_in <= 1'h1;
    tick(2);
    seq = 0;
  endtask

  task automatic convert(input logic [2:0] exp_p, input bit chk);
    int n;
    conversion_start_in <= 1'h1;
    tick(2);
    #1;
    check(busy_out, 1'h1);
    if (chk) begin
      check(conversion_pair_out, exp_p);
    end
    @(posedge clock_in);
    conversion_start_in <= 1'h0;
    n = 0;
    while (busy_out !== 1'h0 && n < 300) begin
      tick(1);
      #1;
      n++;
    end
    check(n < 300, 1'h1);
    seq++;
    @(posedge clock_in);
  endtask

  task automatic rd_word(output logic [15:0] v);
    cs_n_in <= 1'h0;
    tick(1);
    #1;
    check(parallel_data_bus_oe_out, 1'h0);
    @(posedge clock_in);
    rd_n_in <= 1'h0;
    tick(2);
    #1;
    check(parallel_data_bus_oe_out, 1'h1);
    v = parallel_data_bus_out;
    @(posedge clock_in);
    cs_n_in <= 1'h1;
    tick(1);
    #1;
    check(parallel_data_bus_oe_out, 1'h0);
    @(posedge clock_in);
    rd_n_in <= 1'h1;
    tick(1);
  endtask

  task automatic rd_pair(input logic [15:0] ea, input logic [15:0] eb);
    rd_word(va);
    check(va, ea);
    rd_word(va);
    check(va, eb);
  endtask

  // one word framed by select and write
  task automatic wr_word(input logic [15:0] w);
    cs_n_in <= 1'h0;
    parallel_data_bus_in <= w;
    wr_n_in <= 1'h0;
    tick(2);
    wr_n_in <= 1'h1;
    tick(2);
    cs_n_in <= 1'h1;
    parallel_data_bus_in <= ~w;
    tick(2);
  endtask

  // Serial clock stands still outside frames
  task automatic sread(input int n);
    f1 = '0;
    f2 = '0;
    cs_n_in <= 1'h0;
    tick(2);
    #1;
    check(serial_out_first_oe_out, 1'h1);
    check(serial_out_second_oe_out, n == 16);
    for (int i = 0; i < n; i++) begin
      f1 = {f1[30:0], serial_out_first_out};
      f2 = {f2[30:0], serial_out_second_out};
      @(posedge clock_in);
      serial_clock_in <= 1'h1;
      tick(1);
      serial_clock_in <= 1'h0;
      tick(1);
      #1;
    end
    @(posedge clock_in);
    cs_n_in <= 1'h1;
    tick(2);
  endtask

  // ----------------------------------------------
  // Test sequence
  // ----------------------------------------------
  initial begin
    tick(1);
    full_reset(1'h1, 1'h1, 3'h5);
    pair_select_in <= 3'h2;
    tick(1);
    convert(3'h5, 1'h1);
    rd_pair(av(3'h5, 0), bv(3'h5, 0));
    // Pins seen during the previous busy pick the next pair
    for (int k = 0; k < 8; k++) begin
      pair_select_in <= 3'(k);
      tick(1);
      convert(pp, 1'h1);
      rd_pair(av(pp, seq - 1), bv(pp, seq - 1));
      convert(3'(k), 1'h1);
      rd_pair(av(3'(k), seq - 1), bv(3'(k), seq - 1));
      pp = 3'(k);
    end
    convert(3'h7, 1'h1);
    rd_word(va);
    convert(3'h7, 1'h1);
    rd_pair(av(3'h7, seq - 2), bv(3'h7, seq - 2));
    rd_pair(av(3'h7, seq - 1), bv(3'h7, seq - 1));
    pair_select_in <= 3'h3;
    partial_reset_in <= 1'h1;
    tick(2);
    partial_reset_in <= 1'h0;
    tick(1);
    pair_select_in <= 3'h1;
    tick(2);
    convert(3'h3, 1'h1);
    rd_pair(av(3'h3, seq - 1), bv(3'h3, seq - 1));
    base = seq;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      delay <= 8'(i % 9);
      convert(3'h1, 1'h1);
    end
    conversion_start_in <= 1'h1;
    tick(3);
    #1;
    check(busy_out, 1'h0);
    @(posedge clock_in);
    conversion_start_in <= 1'h0;
    tick(1);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      rd_pair(av(3'h1, base + i), bv(3'h1, base + i));
    end
    wr_word({1'h1, CHANNEL_REG_ADDR, 9'h007});
    wr_word({1'h0, CHANNEL_REG_ADDR, 9'h1FF});
    rd_word(va);
    check(va, {1'h0, CHANNEL_REG_ADDR, 9'h000});
    $display("TB: test pin mode parallel done");

    full_reset(1'h0, 1'h1, 3'h4);
    convert(CHANNEL_RESET, 1'h1);
    rd_pair(av(3'h0, 0), bv(3'h0, 0));
    wr_word({1'h1, CHANNEL_REG_ADDR, 9'h006});
    convert(3'h6, 1'h1);
    rd_pair(av(3'h6, 1), bv(3'h6, 1));
    wr_word({1'h0, CHANNEL_REG_ADDR, 9'h1FF});
    rd_word(va);
    check(va, {1'h0, CHANNEL_REG_ADDR, 9'h006});
    wr_word({1'h1, 6'h05, 9'h155});
    wr_word({1'h0, 6'h05, 9'h000});
    rd_word(va);
    check(va, {1'h0, 6'h05, 9'h155});
    rd_word(va);
    check(va, {1'h0, 6'h05, 9'h155});
    // Readback word also leaves on the serial lines
    interface_select_in <= 1'h1;
    tick(1);
    sread(16);
    check(f1[15:0], {1'h0, 6'h05, 9'h155});
    check(f2[15:0], {1'h0, 6'h05, 9'h155});
    interface_select_in <= 1'h0;
    wr_word({1'h1, EXIT_ADDR, EXIT_DATA});
    convert(3'h6, 1'h1);
    rd_pair(av(3'h6, 2), bv(3'h6, 2));
    $display("TB: test register mode done");

    full_reset(1'h1, 1'h1, 3'h2);
    interface_select_in <= 1'h1;
    tick(1);
    convert(3'h2, 1'h1);
    sread(16);
    check(f1[15:0], av(3'h2, 0));
    check(f2[15:0], bv(3'h2, 0));
    full_reset(1'h1, 1'h0, 3'h7);
    single_line_select_in <= 1'h1;
    tick(1);
    convert(3'h7, 1'h1);
    sread(32);
    check(f1, {av(3'h7, 0), bv(3'h7, 0)});
    $display("TB: test serial done");
    stop_test();
  end
endmodule // adc_host_readout_port_tb

// ==== test/ahp_core_model.sv ====
`timescale 1ns/1ps
module ahp_core_model
  import ahp_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic request_in,
  input wire logic [2:0] pair_in,
  input wire logic ready_in,
  input wire logic [7:0] delay_in,
  output logic valid_out,
  output ahp_result_t result_out
);
  logic [8:0] wait_cnt;
  logic [11:0] seq;
  logic [2:0] pair;

  // ----------------------------------------------
  // Conversion timing
  // ----------------------------------------------
  // Delay is set per conversion so the port sees slow and quick cores
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      wait_cnt <= 9'h000;
      seq <= 12'h000;
      pair <= 3'h0;
    end else if (request_in) begin
      wait_cnt <= {1'h0, delay_in} + 9'h001;
      pair <= pair_in;
    end else if (wait_cnt != 9'h000) begin
      wait_cnt <= wait_cnt - 9'h001;
    end else if (valid_out && ready_in) begin
      seq <= seq + 12'h001;
    end
  end

  // ----------------------------------------------
  // Result hand-over
  // ----------------------------------------------
  // Stale data inverted so a late read cannot pass by luck
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      valid_out <= 1'h0;
      result_out <= '0;
    end else if (wait_cnt == 9'h001) begin
      valid_out <= 1'h1;
      result_out.a <= {1'h0, pair, seq};
      result_out.b <= ~{1'h0, pair, seq};
    end else if (valid_out && ready_in) begin
      valid_out <= 1'h0;
      result_out <= ~result_out;
    end
  end
endmodule // ahp_core_model
